// ---- logic/uei_pkg.sv ----
// Package: register map, field layout, reset values and timing for the endpoint DMA interrupt block
package uei_pkg;
  localparam int UEI_AW = 8;
  localparam logic [7:0] UEI_OFF_OUT_TDONE = 8'h00;
  localparam logic [7:0] UEI_OFF_IN_TDONE = 8'h04;
  localparam logic [7:0] UEI_OFF_OUT_RLD = 8'h08;
  localparam logic [7:0] UEI_OFF_IN_RLD = 8'h0c;
  localparam logic [7:0] UEI_OFF_OUT_IE = 8'h10;
  localparam logic [7:0] UEI_OFF_IN_IE = 8'h14;
  localparam logic [7:0] UEI_OFF_GCTL = 8'h18;
  localparam logic [7:0] UEI_OFF_SRC = 8'h1c;
  localparam logic [7:0] UEI_OFF_ISTAT = 8'h20;
  localparam logic [7:0] UEI_OFF_IEN = 8'h24;
  localparam logic [7:0] UEI_OFF_ICLR = 8'h28;
  localparam int UEI_EP_LO = 1;
  localparam int UEI_EP_HI = 7;
  localparam int UEI_SRST_BIT = 0;
  localparam logic [7:0] UEI_FLAG_RST = 8'h00;
  localparam logic [7:0] UEI_IE_RST = 8'h00;
  localparam logic [1:0] UEI_ISTAT_RST = 2'h0;
  localparam int UEI_SRST_NS = 100;
  localparam int UEI_CLK_NS = 25;
  localparam int UEI_SRST_CYC = (UEI_SRST_NS + UEI_CLK_NS - 1) / UEI_CLK_NS;
  localparam logic [4:0] UEI_SRC_NONE = 5'h00;
  localparam logic [4:0] UEI_SRC_TDONE = 5'h10;
  localparam logic [4:0] UEI_SRC_RLD = 5'h18;
  typedef enum logic [1:0] {
    UEI_SR_IDLE = 2'b00,
    UEI_SR_HOLD = 2'b01
  } uei_sr_e;
endpackage

// ---- logic/uei_flag_bank.sv ----
// Sticky flag bank with write-one-clear and clear-on-source-read, one loop iteration per endpoint
`timescale 1ns/1ps
module uei_flag_bank
  import uei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_clr,
  input wire logic [7:0] set_evt,
  input wire logic [7:0] w1c,
  input wire logic [7:0] src_clr,
  output logic [7:0] flags
);
  logic [7:0] next_flags;
  always_comb begin
    next_flags = '0;
    for (int i = UEI_EP_LO; i <= UEI_EP_HI; i++) begin
      // RL1: set wins over write-one and source-read clears; soft clear wins over set
      next_flags[i] = set_evt[i] | (flags[i] & ~w1c[i] & ~src_clr[i]);
      if (soft_clr) begin
        next_flags[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= UEI_FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// ---- logic/uei_soft_reset.sv ----
// Software reset sequencer: holds the module reset a fixed time then self-clears
`timescale 1ns/1ps
module uei_soft_reset
  import uei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  uei_sr_e state;
  uei_sr_e next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_busy;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_busy = busy;
    case (state)
      UEI_SR_IDLE: begin
        if (start) begin
          next_state = UEI_SR_HOLD;
          next_cnt = 8'(UEI_SRST_CYC);
          next_busy = 1'b1;
        end
      end
      UEI_SR_HOLD: begin
        // RL14: self-clear when done
        if (cnt == 8'h01) begin
          next_state = UEI_SR_IDLE;
          next_busy = 1'b0;
        end
        next_cnt = cnt - 8'h01;
      end
      default: begin
        next_state = UEI_SR_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= UEI_SR_IDLE;
      cnt <= 8'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy <= next_busy;
    end
  end
endmodule

// ---- logic/uei_top.sv ----
// Endpoint DMA interrupt controller with software reset, APB register slave
//
// Notes on behaviour
// RL1: DMA reload completion sets reload flag
// RL2: Endpoints 7..1 in bits 7..1, OUT/IN
// RL3: Source-register read clears the named flag
// RL4: Write one clears flag, zero keeps
// RL5: Flag reads one while pending
// RL6: Software writes zeros to bits 15..8
// RL7: Software writes zero to bit 0
// RL8: One enable gates both endpoint requests; code has separate OUT and IN enables, each gating transfer and reload flags
// RL9: Enable one allows, zero blocks
// RL10: Disabled endpoint never requests
// RL11: Soft reset bit resets module only
// RL12: Transfer completion sets transfer flag
// RL13: Soft reset restores registers, module offline
// RL14: Soft reset bit self-clears when done
// RL15: Request when enabled and any flag
// RL16: Enables reset to zero
`timescale 1ns/1ps
module uei_top
  import uei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] out_xfer_done,
  input wire logic [7:0] in_xfer_done,
  input wire logic [7:0] out_reload_done,
  input wire logic [7:0] in_reload_done,
  output logic [7:0] out_ep_irq,
  output logic [7:0] in_ep_irq,
  output logic usb_module_reset,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] out_tdone;
  logic [7:0] in_tdone;
  logic [7:0] out_rld;
  logic [7:0] in_rld;
  logic [7:0] out_dma_irq_enables;
  logic [7:0] in_dma_irq_enables;
  logic [7:0] next_out_ie;
  logic [7:0] next_in_ie;
  logic [1:0] istat;
  logic [1:0] ien;
  logic [1:0] next_istat;
  logic [1:0] next_ien;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] next_out_irq;
  logic [7:0] next_in_irq;
  logic next_irq;
  logic srst_busy;
  logic srst_start;
  logic wr_hit;
  logic rd_hit;
  logic addr_ok;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] w1c_out_t;
  logic [7:0] w1c_in_t;
  logic [7:0] w1c_out_r;
  logic [7:0] w1c_in_r;
  logic [7:0] sc_out_t;
  logic [7:0] sc_in_t;
  logic [7:0] sc_out_r;
  logic [7:0] sc_in_r;
  logic [4:0] src_code;
  logic [7:0] wmask;
  logic [7:0] wb;
  wire logic [7:0] pend_out;
  wire logic [7:0] pend_in;

  // Access phase completes in two cycles; pready is registered so it lands one edge later
  assign wr_hit = psel & penable & pwrite & ~pready;
  assign rd_hit = psel & penable & ~pwrite & ~pready;
  // Bits above the map must be zero, else refused with no effect
  assign addr_ok = paddr[31:UEI_AW] == '0;
  assign wr_ok = wr_hit & addr_ok;
  assign rd_ok = rd_hit & addr_ok;
  // RL2: endpoints live in bits 7..1
  // RL6: upper and bit 0 ignored on write
  assign wmask = 8'hfe;
  assign wb = pwdata[7:0] & wmask;

  ////////////////////////////////////////////////////////////////////////////
  // RL8: one enable gates both flags
  // RL9: enable one allows, zero blocks
  for (genvar g = 0; g < 8; g++) begin : g_pend
    if (g >= UEI_EP_LO) begin : g_ep
      assign pend_out[g] = out_dma_irq_enables[g] & (out_tdone[g] | out_rld[g]);
      assign pend_in[g] = in_dma_irq_enables[g] & (in_tdone[g] | in_rld[g]);
    end else begin : g_none
      // Bit 0 has no endpoint, so its request is tied low
      assign pend_out[g] = 1'b0;
      assign pend_in[g] = 1'b0;
    end
  end

  // Source field: transfers before reloads, OUT before IN, lowest endpoint first
  // Kind in bits 4:3: 10 OUT transfer, 11 OUT reload, 01 IN transfer, 00 IN reload
  // Endpoint field is never zero, so IN reload codes stay apart from none
  always_comb begin
    src_code = UEI_SRC_NONE;
    for (int i = UEI_EP_HI; i >= UEI_EP_LO; i--) begin
      if (in_dma_irq_enables[i] & in_rld[i]) begin
        src_code = 5'(i);
      end
    end

    for (int i = UEI_EP_HI; i >= UEI_EP_LO; i--) begin
      if (out_dma_irq_enables[i] & out_rld[i]) begin
        src_code = UEI_SRC_RLD | 5'(i);
      end
    end

    for (int i = UEI_EP_HI; i >= UEI_EP_LO; i--) begin
      if (in_dma_irq_enables[i] & in_tdone[i]) begin
        src_code = 5'h08 | 5'(i);
      end
    end

    for (int i = UEI_EP_HI; i >= UEI_EP_LO; i--) begin
      if (out_dma_irq_enables[i] & out_tdone[i]) begin
        src_code = UEI_SRC_TDONE | 5'(i);
      end
    end
  end

  // RL3: reading the source register clears the named flag
  always_comb begin
    sc_out_t = '0;
    sc_in_t = '0;
    sc_out_r = '0;
    sc_in_r = '0;
    if (rd_ok && paddr[UEI_AW-1:0] == UEI_OFF_SRC && src_code != UEI_SRC_NONE) begin
      // Kind field picks the bank, endpoint field picks the bit
      if (src_code[4:3] == 2'b10) begin
        sc_out_t[src_code[2:0]] = 1'b1;
      end else if (src_code[4:3] == 2'b11) begin
        sc_out_r[src_code[2:0]] = 1'b1;
      end else if (src_code[4:3] == 2'b01) begin
        sc_in_t[src_code[2:0]] = 1'b1;
      end else begin
        sc_in_r[src_code[2:0]] = 1'b1;
      end
    end
  end

  // RL4: write one clears, zero keeps
  always_comb begin
    w1c_out_t = '0;
    w1c_in_t = '0;
    w1c_out_r = '0;
    w1c_in_r = '0;
    // Set still wins inside the flag bank if an event lands now
    if (wr_ok) begin
      if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_TDONE) begin
        w1c_out_t = wb;
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_TDONE) begin
        w1c_in_t = wb;
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_RLD) begin
        w1c_out_r = wb;
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_RLD) begin
        w1c_in_r = wb;
      end
    end
  end

  // RL11: soft reset only when idle
  // A write while the sequencer runs is dropped, not queued
  assign srst_start = wr_ok && paddr[UEI_AW-1:0] == UEI_OFF_GCTL && pwdata[UEI_SRST_BIT] && !srst_busy;

  ////////////////////////////////////////////////////////////////////////////
  // RL12: transfer completion flags
  uei_flag_bank u_out_t (.clk_sys(clk_sys), .rst(rst), .soft_clr(srst_busy), .set_evt(out_xfer_done & wmask),
    .w1c(w1c_out_t), .src_clr(sc_out_t), .flags(out_tdone));
  uei_flag_bank u_in_t (.clk_sys(clk_sys), .rst(rst), .soft_clr(srst_busy), .set_evt(in_xfer_done & wmask),
    .w1c(w1c_in_t), .src_clr(sc_in_t), .flags(in_tdone));
  // RL1: reload completion flags
  uei_flag_bank u_out_r (.clk_sys(clk_sys), .rst(rst), .soft_clr(srst_busy), .set_evt(out_reload_done & wmask),
    .w1c(w1c_out_r), .src_clr(sc_out_r), .flags(out_rld));
  uei_flag_bank u_in_r (.clk_sys(clk_sys), .rst(rst), .soft_clr(srst_busy), .set_evt(in_reload_done & wmask),
    .w1c(w1c_in_r), .src_clr(sc_in_r), .flags(in_rld));
  uei_soft_reset u_srst (.clk_sys(clk_sys), .rst(rst), .start(srst_start), .busy(srst_busy));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_out_ie = out_dma_irq_enables;
    next_in_ie = in_dma_irq_enables;
    next_ien = ien;
    next_istat = istat;
    // Events sticky; set wins over clear
    // Clear register is write-only, one bits clear status
    if (wr_ok && paddr[UEI_AW-1:0] == UEI_OFF_ICLR) begin
      next_istat = istat & ~pwdata[1:0];
    end
    next_istat[0] = next_istat[0] | (|(out_xfer_done & wmask)) | (|(in_xfer_done & wmask));
    next_istat[1] = next_istat[1] | (|(out_reload_done & wmask)) | (|(in_reload_done & wmask));
    if (wr_ok) begin
      if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_IE) begin
        next_out_ie = wb;
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_IE) begin
        next_in_ie = wb;
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IEN) begin
        next_ien = pwdata[1:0];
      end
    end
    // RL13: soft reset restores defaults
    if (srst_busy) begin
      next_out_ie = UEI_IE_RST;
      next_in_ie = UEI_IE_RST;
      next_ien = UEI_ISTAT_RST;
      next_istat = UEI_ISTAT_RST;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = psel & penable & ~pready;
    // Refused accesses answer with zero data and change nothing
    if (rd_ok) begin
      // RL5: flags read as pending state
      if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_TDONE) begin
        next_prdata = {24'h0, out_tdone};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_TDONE) begin
        next_prdata = {24'h0, in_tdone};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_RLD) begin
        next_prdata = {24'h0, out_rld};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_RLD) begin
        next_prdata = {24'h0, in_rld};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_OUT_IE) begin
        next_prdata = {24'h0, out_dma_irq_enables};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IN_IE) begin
        next_prdata = {24'h0, in_dma_irq_enables};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_GCTL) begin
        next_prdata = {31'h0, srst_busy};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_SRC) begin
        next_prdata = {27'h0, src_code};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_ISTAT) begin
        next_prdata = {30'h0, istat};
      end else if (paddr[UEI_AW-1:0] == UEI_OFF_IEN) begin
        next_prdata = {30'h0, ien};
      end else if (paddr[UEI_AW-1:0] != UEI_OFF_ICLR) begin
        next_pslverr = 1'b1;
      end
    end else if (wr_ok) begin
      if (paddr[UEI_AW-1:0] > UEI_OFF_ICLR || paddr[UEI_AW-1:0] == UEI_OFF_SRC
          || paddr[UEI_AW-1:0] == UEI_OFF_ISTAT || paddr[1:0] != 2'b00) begin
        next_pslverr = 1'b1;
      end
    end
    if (paddr[31:UEI_AW] != '0 && (rd_hit || wr_hit)) begin
      next_pslverr = 1'b1;
    end
  end

  // RL15: request when enabled and flagged
  // RL10: disabled endpoint stays quiet
  assign next_out_irq = pend_out;
  assign next_in_irq = pend_in;
  assign next_irq = |(istat & ien);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // RL16: enables clear at reset
      out_dma_irq_enables <= UEI_IE_RST;
      in_dma_irq_enables <= UEI_IE_RST;
      ien <= UEI_ISTAT_RST;
      istat <= UEI_ISTAT_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      out_ep_irq <= 8'h00;
      in_ep_irq <= 8'h00;
      irq <= 1'b0;
      usb_module_reset <= 1'b0;
    end else begin
      out_dma_irq_enables <= next_out_ie;
      in_dma_irq_enables <= next_in_ie;
      ien <= next_ien;
      istat <= next_istat;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      out_ep_irq <= next_out_irq;
      in_ep_irq <= next_in_irq;
      irq <= next_irq;
      // RL11: module-only reset output
      usb_module_reset <= srst_busy;
    end
  end
endmodule

// ---- tb/uei_props.sv ----
// Port checker for the endpoint interrupt block
`timescale 1ns/1ps
module uei_props
  import uei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] out_ep_irq,
  input wire logic [7:0] in_ep_irq,
  input wire logic usb_module_reset,
  input wire logic irq
);
  wire acc = psel && penable && !pready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  pready_answer_a: assert property (acc |=> pready)
    else $error("no pready after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_valid_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_a: assert property (acc && paddr[31:8] != 24'h0 |=> pslverr)
    else $error("out of range address accepted");
  bit0_quiet_a: assert property (!out_ep_irq[0] && !in_ep_irq[0])
    else $error("endpoint zero request");
  srst_start_a: assert property (acc && pwrite && paddr == {24'h0, UEI_OFF_GCTL} && pwdata[0]
    |-> ##[1:3] usb_module_reset)
    else $error("soft reset not started");
  srst_len_a: assert property ($rose(usb_module_reset) |-> usb_module_reset [*4] ##1 !usb_module_reset)
    else $error("soft reset length wrong");
  srst_quiet_a: assert property (usb_module_reset [*2] |-> out_ep_irq == 8'h00 && in_ep_irq == 8'h00 && !irq)
    else $error("request during soft reset");
endmodule
////////////////////////////////////////////////////////////////
bind uei_top uei_props u_props (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .out_ep_irq(out_ep_irq),
  .in_ep_irq(in_ep_irq), .usb_module_reset(usb_module_reset), .irq(irq));

// ---- tb/test_uei_top.sv ----
// Self-checking bench for the endpoint interrupt block
`timescale 1ns/1ps
module test_uei_top;
  import uei_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, usb_module_reset, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] out_xfer_done, in_xfer_done, out_reload_done, in_reload_done, out_ep_irq, in_ep_irq, b;
  int n_mismatch, compares, cnt;
  uei_top uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_xfer_done(out_xfer_done),
    .in_xfer_done(in_xfer_done), .out_reload_done(out_reload_done), .in_reload_done(in_reload_done),
    .out_ep_irq(out_ep_irq), .in_ep_irq(in_ep_irq), .usb_module_reset(usb_module_reset), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Request held until pready is seen at an edge
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      $display("[ERR] %0t pready timeout", $time);
      print_verdict();
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(logic [31:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask
  task automatic ev(logic [7:0] ox, logic [7:0] ix, logic [7:0] orl, logic [7:0] irl);
    @(posedge clk_sys);
    out_xfer_done <= ox;
    in_xfer_done <= ix;
    out_reload_done <= orl;
    in_reload_done <= irl;
    @(posedge clk_sys);
    out_xfer_done <= 8'h00;
    in_xfer_done <= 8'h00;
    out_reload_done <= 8'h00;
    in_reload_done <= 8'h00;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset();
    for (int a = 0; a <= 40; a += 4)
      rdchk(32'(a), 32'h0);
  endtask
  // Every endpoint, all four flag kinds, with requests disabled
  task automatic s_flags();
    for (int k = 1; k < 8; k++) begin
      b = 8'h01 << k;
      ev(b, b, b, b);
      chk_word({16'h0, out_ep_irq, in_ep_irq}, 32'h0);
      for (int r = 0; r < 4; r++) begin
        rdchk(32'(r * 4), {24'h0, b});
        wr(32'(r * 4), 32'h0);
        rdchk(32'(r * 4), {24'h0, b});
        wr(32'(r * 4), {24'h0, b});
        rdchk(32'(r * 4), 32'h0);
      end
    end
  endtask
  task automatic s_gate();
    wr(32'h10, 32'h08);
    wr(32'h14, 32'h20);
    rdchk(32'h14, 32'h20);
    ev(8'h08, 8'h00, 8'h00, 8'h20);
    chk_word({16'h0, out_ep_irq, in_ep_irq}, 32'h0820);
    wr(32'h00, 32'h08);
    tick(2);
    chk_word({24'h0, out_ep_irq}, 32'h0);
    ev(8'h04, 8'h00, 8'h08, 8'h00);
    chk_word({24'h0, out_ep_irq}, 32'h08);
    wr(32'h10, 32'h0);
    tick(2);
    chk_word({24'h0, out_ep_irq}, 32'h0);
    wr(32'h00, 32'h04);
    wr(32'h08, 32'h08);
    wr(32'h0c, 32'h20);
  endtask
  task automatic s_src();
    wr(32'h10, 32'h06);
    ev(8'h00, 8'h00, 8'h04, 8'h00);
    rdchk(32'h1c, 32'h1a);
    rdchk(32'h08, 32'h0);
    ev(8'h02, 8'h00, 8'h00, 8'h00);
    rdchk(32'h1c, 32'h11);
    rdchk(32'h00, 32'h0);
    ev(8'h00, 8'h20, 8'h20, 8'h00);
    rdchk(32'h1c, 32'h0d);
    rdchk(32'h04, 32'h0);
    rdchk(32'h08, 32'h20);
    wr(32'h08, 32'h20);
    ev(8'h00, 8'h00, 8'h00, 8'h20);
    rdchk(32'h1c, 32'h05);
    rdchk(32'h0c, 32'h0);
  endtask
  task automatic s_irq();
    wr(32'h28, 32'h3);
    wr(32'h24, 32'h2);
    ev(8'h00, 8'h00, 8'h00, 8'h02);
    chk_bit(irq, 1'b1);
    rdchk(32'h20, 32'h2);
    wr(32'h24, 32'h0);
    tick(2);
    chk_bit(irq, 1'b0);
    wr(32'h24, 32'h2);
    tick(2);
    chk_bit(irq, 1'b1);
    wr(32'h28, 32'h2);
    tick(2);
    chk_bit(irq, 1'b0);
    ev(8'h02, 8'h00, 8'h00, 8'h00);
    rdchk(32'h20, 32'h1);
  endtask
  // Pending flags and enables must not survive the soft reset
  task automatic s_srst();
    wr(32'h10, 32'h02);
    wr(32'h24, 32'h1);
    wr(32'h18, 32'h1);
    cnt = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      if (usb_module_reset === 1'b1)
        cnt++;
    end
    chk_word(32'(cnt), 32'd4);
    rdchk(32'h18, 32'h0);
    for (int a = 0; a <= 36; a += 4)
      rdchk(32'(a), 32'h0);
    chk_bit(irq, 1'b0);
  endtask
  task automatic s_err();
    apb(1'b0, 32'h40, 32'h0);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h0);
    apb(1'b1, 32'h110, 32'h02);
    chk_bit(er, 1'b1);
    rdchk(32'h10, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, psel, penable, pwrite} = 4'h8;
    {paddr, pwdata} = 64'h0;
    {out_xfer_done, in_xfer_done, out_reload_done, in_reload_done} = 32'h0;
    n_mismatch = 0;
    compares = 0;
    tick(8);
    rst <= 1'b0;
    s_reset();
    s_flags();
    s_gate();
    s_src();
    s_irq();
    s_srst();
    s_err();
    print_verdict();
  end
endmodule
